// [logic/tmw_pkg.sv]
// package: register map, field layout and encodings of the waveform timer
package tmw_pkg;
  localparam logic [11:0] TMW_CTRL_OFS = 12'h000;
  localparam logic [11:0] TMW_COUNT_OFS = 12'h004;
  localparam logic [11:0] TMW_CMP_OFS = 12'h008;
  localparam logic [11:0] TMW_FLAG_OFS = 12'h00c;
  localparam int TMW_MODE_LSB = 0;
  localparam int TMW_ACT_LSB = 2;
  localparam int TMW_DIR_BIT = 4;
  localparam int TMW_OVF_BIT = 0;
  localparam int TMW_CMF_BIT = 1;
  localparam int TMW_OUT_BIT = 2;
  localparam logic [7:0] TMW_MAX = 8'hff;
  localparam logic [7:0] TMW_BOTTOM = 8'h00;
  localparam logic [7:0] TMW_ONE = 8'h01;
  localparam logic [31:0] TMW_ZERO32 = 32'h0000_0000;
  typedef enum logic [1:0] {
    TMW_NORMAL = 2'h0,
    TMW_DUAL = 2'h1,
    TMW_CLEAR_ON_MATCH = 2'h2,
    TMW_SINGLE = 2'h3
  } tmw_mode_t;
  localparam logic [1:0] TMW_ACT_OFF = 2'h0;
  localparam logic [1:0] TMW_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TMW_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TMW_ACT_SET = 2'h3;
endpackage

// [logic/tmw_cmp_buf.sv]
// compare value store with direct or buffered update
`timescale 1ns/1ps
module tmw_cmp_buf
  import tmw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic direct,
  input wire logic load,
  output logic [7:0] buf_val,
  output logic [7:0] cmp_val
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_val <= TMW_BOTTOM;
    end else if (wr) begin
      buf_val <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_val <= TMW_BOTTOM;
    end else if (wr && direct) begin
      cmp_val <= wdata;
    end else if (load && !direct) begin
      cmp_val <= buf_val;
    end
  end
endmodule

// [logic/tmw_pin.sv]
// pin driver: port function or compare output, gated by direction
`timescale 1ns/1ps
module tmw_pin
  import tmw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic port_out,
  input wire logic dir_out,
  input wire logic [1:0] action,
  input wire logic wave,
  output logic pin_o,
  output logic pin_oe_n
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_o <= (action == TMW_ACT_OFF) ? port_out : wave;
      pin_oe_n <= !dir_out;
    end
  end
endmodule

// [logic/tmw_timer.sv]
// top: 8-bit timer with four waveform modes and an apb register slave
// Operation
// - mode 0 counts up only and wraps from 0xff to 0x00.
// - mode 0 sets overflow flag as count becomes zero; software clears.
// - mode 2 clears the counter when it equals the compare value.
// - mode 2 compare unbuffered; value below count means wrap before match.
// - mode 2 with action 1 toggles output on every match.
// - mode 2 still sets overflow flag on passing max to zero.
// - mode 2 raises compare match flag every period.
// - mode 3 counts zero to max then clears next tick.
// - mode 3 action 2 clears on match, sets at bottom; 3 opposite.
// - mode 3 sets overflow flag as counter wraps from max to zero.
// - mode 3 compare zero gives spike, max gives constant level.
// - mode 3 action 1 toggles on match, compare stays buffered.
// - mode 1 counts up, turns at max without holding, down to zero.
// - mode 1 action 2 clears on up match, sets on down; 3 inverts.
// - mode 1 sets overflow flag when counter reaches zero.
// - mode 1 compare zero gives constant low, max constant high.
// - mode 1 output fixes symmetry at max without a match.
// - action bits never change the counting sequence.
// - pin shows compare output only while direction is output.
// - mode 3 period is 256 ticks.
// - mode 1 period is 510 ticks.
// - match flag sets one tick later; count write blocks next-tick match.
// - compare immediate in modes 0,2; at top in mode 1; bottom mode 3.
// - software count write beats clear or count in same cycle.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module tmw_timer
  import tmw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_tick,
  input wire logic port_out,
  output logic compare_output_pin,
  output logic compare_output_pin_oe_n,
  output logic overflow_flag,
  output logic compare_match_flag
);
  // ==========================================================
  // apb decode
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [1:0] waveform_mode_bits;
  logic [1:0] output_action_bits;
  logic dir_out_r;
  logic [7:0] count_value;
  logic [7:0] count_nxt;
  logic [7:0] compare_value;
  logic [7:0] cmp_buf;
  logic compare_output;
  logic out_nxt;
  logic down_r;
  logic down_nxt;
  logic block_r;
  logic match_r;
  logic ovf_set;
  logic cnt_wr;
  logic cmp_wr;
  logic match;
  logic load_top;
  logic load_bot;
  logic [31:0] rd_nxt;
  tmw_mode_t mode;

  function automatic logic sel(input logic [11:0] a, input logic [11:0] ofs);
    sel = (a == ofs);
  endfunction

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign hit = sel(paddr, TMW_CTRL_OFS) || sel(paddr, TMW_COUNT_OFS) ||
               sel(paddr, TMW_CMP_OFS) || sel(paddr, TMW_FLAG_OFS);
  assign cnt_wr = wr_en && sel(paddr, TMW_COUNT_OFS);
  assign cmp_wr = wr_en && sel(paddr, TMW_CMP_OFS);
  assign mode = tmw_mode_t'(waveform_mode_bits);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_mode_bits <= TMW_NORMAL;
      output_action_bits <= TMW_ACT_OFF;
      dir_out_r <= 1'b0;
    end else if (wr_en && sel(paddr, TMW_CTRL_OFS)) begin
      waveform_mode_bits <= pwdata[TMW_MODE_LSB +: 2];
      output_action_bits <= pwdata[TMW_ACT_LSB +: 2];
      dir_out_r <= pwdata[TMW_DIR_BIT];
    end
  end

  always_comb begin
    rd_nxt = TMW_ZERO32;
    if (sel(paddr, TMW_CTRL_OFS)) begin
      rd_nxt[TMW_MODE_LSB +: 2] = waveform_mode_bits;
      rd_nxt[TMW_ACT_LSB +: 2] = output_action_bits;
      rd_nxt[TMW_DIR_BIT] = dir_out_r;
    end else if (sel(paddr, TMW_COUNT_OFS)) begin
      rd_nxt[7:0] = count_value;
    end else if (sel(paddr, TMW_CMP_OFS)) begin
      rd_nxt[7:0] = cmp_buf;
    end else if (sel(paddr, TMW_FLAG_OFS)) begin
      rd_nxt[TMW_OVF_BIT] = overflow_flag;
      rd_nxt[TMW_CMF_BIT] = compare_match_flag;
      rd_nxt[TMW_OUT_BIT] = compare_output;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= TMW_ZERO32;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_nxt;
    end
  end

  // ==========================================================
  // compare value and counter
  assign load_top = timer_tick && (mode == TMW_DUAL) && (count_value == TMW_MAX);
  assign load_bot = timer_tick && (mode == TMW_SINGLE) && (count_value == TMW_MAX);

  tmw_cmp_buf u_cmp (
    .pclk(pclk),
    .presetn(presetn),
    .wr(cmp_wr),
    .wdata(pwdata[7:0]),
    .direct(mode == TMW_NORMAL || mode == TMW_CLEAR_ON_MATCH),
    .load(load_top || load_bot),
    .buf_val(cmp_buf),
    .cmp_val(compare_value)
  );

  assign match = (count_value == compare_value) && !block_r;

  // output action bits take no part in the count sequence
  always_comb begin
    count_nxt = count_value + TMW_ONE;
    down_nxt = down_r;
    unique case (mode)
      TMW_NORMAL: count_nxt = count_value + TMW_ONE;
      TMW_CLEAR_ON_MATCH: begin
        if (count_value == compare_value) begin
          count_nxt = TMW_BOTTOM;
        end
      end
      TMW_SINGLE: count_nxt = count_value + TMW_ONE;
      TMW_DUAL: begin
        if (!down_r && count_value == TMW_MAX) begin
          down_nxt = 1'b1;
          count_nxt = count_value - TMW_ONE;
        end else if (down_r && count_value == TMW_BOTTOM) begin
          down_nxt = 1'b0;
          count_nxt = count_value + TMW_ONE;
        end else if (down_r) begin
          count_nxt = count_value - TMW_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= TMW_BOTTOM;
      down_r <= 1'b0;
    end else if (cnt_wr) begin
      count_value <= pwdata[7:0];
    end else if (timer_tick) begin
      count_value <= count_nxt;
      down_r <= (mode == TMW_DUAL) ? down_nxt : 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_r <= 1'b0;
    end else if (cnt_wr) begin
      block_r <= 1'b1;
    end else if (timer_tick) begin
      block_r <= 1'b0;
    end
  end

  // ==========================================================
  // flags
  always_comb begin
    unique case (mode)
      TMW_DUAL: ovf_set = down_r && count_value == TMW_ONE;
      TMW_SINGLE: ovf_set = count_value == TMW_MAX;
      default: ovf_set = count_value == TMW_MAX && count_nxt == TMW_BOTTOM;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_r <= 1'b0;
    end else if (timer_tick) begin
      match_r <= match;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (timer_tick && !cnt_wr && ovf_set) begin
      overflow_flag <= 1'b1; // set wins over clear
    end else if (wr_en && sel(paddr, TMW_FLAG_OFS) && pwdata[TMW_OVF_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_match_flag <= 1'b0;
    end else if (timer_tick && match_r) begin
      compare_match_flag <= 1'b1;
    end else if (wr_en && sel(paddr, TMW_FLAG_OFS) && pwdata[TMW_CMF_BIT]) begin
      compare_match_flag <= 1'b0;
    end
  end

  // ==========================================================
  // waveform
  always_comb begin
    out_nxt = compare_output;
    unique case (mode)
      TMW_SINGLE: begin
        if (output_action_bits == TMW_ACT_TOGGLE) begin
          if (match) out_nxt = !compare_output;
        end else if (output_action_bits[1]) begin
          if (count_value == TMW_MAX) begin
            out_nxt = !output_action_bits[0];
          end else if (match) begin
            out_nxt = output_action_bits[0];
          end
        end
      end
      TMW_DUAL: begin
        if (output_action_bits[1]) begin
          if (count_value == TMW_MAX && !down_r) begin
            out_nxt = (compare_value == TMW_MAX) ? !output_action_bits[0]
                      : output_action_bits[0];
          end else if (count_value == TMW_BOTTOM && compare_value == TMW_BOTTOM) begin
            // floor level beats the bottom match, else a zero compare would pulse
            out_nxt = output_action_bits[0];
          end else if (match && !down_r) begin
            out_nxt = output_action_bits[0];
          end else if (match && down_r) begin
            out_nxt = !output_action_bits[0];
          end else if (count_value == TMW_BOTTOM && down_r && compare_value != TMW_BOTTOM) begin
            out_nxt = !output_action_bits[0];
          end
        end
      end
      default: begin
        if (match) begin
          unique case (output_action_bits)
            TMW_ACT_TOGGLE: out_nxt = !compare_output;
            TMW_ACT_CLEAR: out_nxt = 1'b0;
            TMW_ACT_SET: out_nxt = 1'b1;
            TMW_ACT_OFF: out_nxt = compare_output;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output <= 1'b0;
    end else if (timer_tick) begin
      compare_output <= out_nxt;
    end
  end

  tmw_pin u_pin (
    .pclk(pclk),
    .presetn(presetn),
    .port_out(port_out),
    .dir_out(dir_out_r),
    .action(output_action_bits),
    .wave(compare_output),
    .pin_o(compare_output_pin),
    .pin_oe_n(compare_output_pin_oe_n)
  );

  // ==========================================================
  // checks
  count_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_wr |=> count_value == $past(pwdata[7:0])) else $error("count write lost");
  no_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
    !timer_tick && !cnt_wr |=> $stable(count_value)) else $error("count moved without tick");
  wrap_norm_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && !cnt_wr && mode == TMW_NORMAL && count_value == TMW_MAX |=> count_value == TMW_BOTTOM && overflow_flag)
    else $error("normal wrap bad");
  ctc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && !cnt_wr && mode == TMW_CLEAR_ON_MATCH && count_value == compare_value |=> count_value == TMW_BOTTOM)
    else $error("clear on match missed");
  dual_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && !cnt_wr && mode == TMW_DUAL && count_value == TMW_MAX && !down_r |=> down_r)
    else $error("dual slope did not turn");
  ovf_fast_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && mode == TMW_SINGLE && count_value == TMW_MAX && !cnt_wr |=> overflow_flag)
    else $error("fast overflow missing");
  cmf_late_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && match_r |=> compare_match_flag) else $error("match flag late");
  pin_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    !dir_out_r |=> compare_output_pin_oe_n) else $error("pin driven as input");
  block_a: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_wr |=> !match) else $error("match not blocked");
  dual_floor_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && mode == TMW_DUAL && output_action_bits[1] && compare_value == TMW_BOTTOM &&
    count_value == TMW_BOTTOM |=> compare_output == $past(output_action_bits[0])) else $error("dual floor level bad");
  fast_top_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && mode == TMW_SINGLE && output_action_bits[1] && count_value == TMW_MAX
    |=> compare_output != $past(output_action_bits[0])) else $error("fast bottom level bad");
  ovf_dual_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_tick && !cnt_wr && mode == TMW_DUAL && down_r && count_value == TMW_ONE
    |=> overflow_flag) else $error("dual overflow missing");
  pin_port_a: assert property (@(posedge pclk) disable iff (!presetn)
    output_action_bits == TMW_ACT_OFF |=> compare_output_pin == $past(port_out)) else $error("port function lost");
  cov_ctc_c: cover property (@(posedge pclk) mode == TMW_CLEAR_ON_MATCH && match && timer_tick);
  cov_spike_c: cover property (@(posedge pclk) mode == TMW_SINGLE && match && count_value == TMW_BOTTOM && timer_tick);
  cov_fast_c: cover property (@(posedge pclk) mode == TMW_SINGLE && load_bot);
  cov_dual_c: cover property (@(posedge pclk) mode == TMW_DUAL && down_r && count_value == TMW_BOTTOM);
endmodule

// [sim/tmw_timer_tb.sv]
// testbench: self-checking apb and waveform scenarios for the timer
`timescale 1ns/1ps
module tmw_timer_tb
  import tmw_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, timer_tick, port_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic pready, pslverr, rerr, compare_output_pin, compare_output_pin_oe_n, overflow_flag, compare_match_flag;
  int errors = 0;
  int checks = 0;
  int cyc = 0;

  tmw_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .port_out(port_out), .compare_output_pin(compare_output_pin),
    .compare_output_pin_oe_n(compare_output_pin_oe_n), .overflow_flag(overflow_flag),
    .compare_match_flag(compare_match_flag));

  // ==========================================
  // clock, timeout and closing
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop;
    end
  end

  // ==========================================
  // compare and bus tasks
  task automatic fail(string m);
    errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic chk32(logic [31:0] got, logic [31:0] exp, string m);
    checks++;
    if (got !== exp) fail($sformatf("%s got %h exp %h", m, got, exp));
  endtask

  task automatic chk1(logic got, logic exp, string m);
    checks++;
    if (got !== exp) fail($sformatf("%s got %b exp %b", m, got, exp));
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    // pre-edge values: the access edge itself
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let outputs settle before callers look at them
    @(negedge pclk);
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(logic [11:0] a, logic [31:0] mask, logic [31:0] exp, string m);
    apb(1'b0, a, 32'h0000_0000);
    chk32(rdat & mask, exp, m);
  endtask

  task automatic cnt(logic [7:0] v);
    rdchk(TMW_COUNT_OFS, 32'h0000_00ff, {24'h00_0000, v}, "count");
  endtask

  task automatic wave(logic v);
    rdchk(TMW_FLAG_OFS, 32'h0000_0004, {29'h0, v, 2'h0}, "wave state");
  endtask

  // n consecutive tick pulses
  task automatic tk(int n);
    @(posedge pclk);
    timer_tick <= 1'b1;
    repeat (n) @(posedge pclk);
    timer_tick <= 1'b0;
    @(negedge pclk);
  endtask

  function automatic logic [31:0] cw(logic [1:0] m, logic [1:0] a, logic d);
    return {27'h0, d, a, m};
  endfunction

  // ==========================================
  // scenarios
  task automatic t_reset;
    rdchk(TMW_CTRL_OFS, 32'hffff_ffff, 32'h0000_0000, "ctrl reset");
    cnt(8'h00);
    rdchk(TMW_CMP_OFS, 32'hffff_ffff, 32'h0000_0000, "cmp reset");
    rdchk(TMW_FLAG_OFS, 32'hffff_ffff, 32'h0000_0000, "flag reset");
    chk1(compare_output_pin_oe_n, 1'b1, "oe_n reset");
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk1(rerr, 1'b1, "unmapped err");
    chk32(rdat, 32'h0000_0000, "unmapped data");
    $display("test reset done");
  endtask

  task automatic t_normal;
    wr(TMW_COUNT_OFS, 32'h0000_00fd);
    repeat (6) @(posedge pclk);
    cnt(8'hfd);
    tk(2);
    cnt(8'hff);
    chk1(overflow_flag, 1'b0, "ovf early");
    tk(1);
    cnt(8'h00);
    chk1(overflow_flag, 1'b1, "ovf wrap");
    wr(TMW_FLAG_OFS, 32'h0000_0001);
    chk1(overflow_flag, 1'b0, "ovf clear");
    wr(TMW_COUNT_OFS, 32'h0000_0000);
    tk(2);
    chk1(compare_match_flag, 1'b0, "match blocked");
    $display("test normal done");
  endtask

  task automatic t_ctc;
    wr(TMW_CTRL_OFS, cw(2'h2, TMW_ACT_TOGGLE, 1'b1));
    wr(TMW_CMP_OFS, 32'h0000_0003);
    wr(TMW_COUNT_OFS, 32'h0000_0000);
    wr(TMW_FLAG_OFS, 32'h0000_0003);
    tk(4);
    cnt(8'h00);
    tk(1);
    chk1(compare_match_flag, 1'b1, "match flag");
    wave(1'b1);
    chk1(compare_output_pin, 1'b1, "pin");
    chk1(compare_output_pin_oe_n, 1'b0, "oe_n on");
    tk(3);
    wave(1'b0);
    wr(TMW_COUNT_OFS, 32'h0000_0010);
    wr(TMW_FLAG_OFS, 32'h0000_0003);
    tk(239);
    cnt(8'hff);
    chk1(overflow_flag, 1'b0, "ctc ovf early");
    tk(1);
    cnt(8'h00);
    chk1(overflow_flag, 1'b1, "ctc ovf");
    wr(TMW_CTRL_OFS, cw(2'h2, TMW_ACT_TOGGLE, 1'b0));
    @(negedge pclk);
    chk1(compare_output_pin_oe_n, 1'b1, "oe_n off");
    $display("test ctc done");
  endtask

  task automatic t_fast;
    wr(TMW_CTRL_OFS, cw(2'h3, TMW_ACT_OFF, 1'b1));
    @(posedge pclk);
    port_out <= 1'b1;
    wr(TMW_COUNT_OFS, 32'h0000_0000);
    wr(TMW_FLAG_OFS, 32'h0000_0003);
    chk1(compare_output_pin, 1'b1, "port function");
    tk(254);
    cnt(8'hfe);
    chk1(overflow_flag, 1'b0, "fast ovf early");
    tk(2);
    cnt(8'h00);
    chk1(overflow_flag, 1'b1, "fast ovf");
    wr(TMW_CMP_OFS, 32'h0000_0080);
    wr(TMW_CTRL_OFS, cw(2'h3, TMW_ACT_CLEAR, 1'b1));
    tk(256);
    tk(64);
    cnt(8'h40);
    wave(1'b1);
    tk(128);
    wave(1'b0);
    chk1(compare_output_pin, 1'b0, "fast pin");
    wr(TMW_CTRL_OFS, cw(2'h3, TMW_ACT_SET, 1'b1));
    tk(128);
    wave(1'b0);
    tk(128);
    wave(1'b1);
    $display("test fast done");
  endtask

  task automatic t_dual;
    wr(TMW_CTRL_OFS, cw(2'h1, TMW_ACT_CLEAR, 1'b1));
    wr(TMW_CMP_OFS, 32'h0000_0080);
    wr(TMW_COUNT_OFS, 32'h0000_0000);
    wr(TMW_FLAG_OFS, 32'h0000_0003);
    tk(255);
    cnt(8'hff);
    tk(1);
    cnt(8'hfe);
    tk(253);
    cnt(8'h01);
    chk1(overflow_flag, 1'b0, "dual ovf early");
    tk(1);
    cnt(8'h00);
    chk1(overflow_flag, 1'b1, "dual ovf");
    tk(192);
    wave(1'b0);
    tk(254);
    cnt(8'h40);
    wave(1'b1);
    wr(TMW_CTRL_OFS, cw(2'h1, TMW_ACT_SET, 1'b1));
    tk(510);
    cnt(8'h40);
    wave(1'b0);
    $display("test dual done");
  endtask

  task automatic t_extreme;
    wr(TMW_CTRL_OFS, cw(2'h1, TMW_ACT_CLEAR, 1'b1));
    wr(TMW_CMP_OFS, 32'h0000_0000);
    tk(510);
    tk(100);
    wave(1'b0);
    tk(300);
    wave(1'b0);
    wr(TMW_CTRL_OFS, cw(2'h1, TMW_ACT_SET, 1'b1));
    tk(200);
    wave(1'b1);
    wr(TMW_CTRL_OFS, cw(2'h3, TMW_ACT_CLEAR, 1'b1));
    wr(TMW_CMP_OFS, 32'h0000_00ff);
    tk(300);
    wave(1'b1);
    wr(TMW_CMP_OFS, 32'h0000_0000);
    tk(185);
    wave(1'b1);
    tk(1);
    wave(1'b1);
    tk(1);
    wave(1'b0);
    wr(TMW_CTRL_OFS, cw(2'h3, TMW_ACT_TOGGLE, 1'b1));
    tk(256);
    wave(1'b1);
    tk(256);
    wave(1'b0);
    $display("test extreme done");
  endtask

  // ==========================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    timer_tick = 1'b0;
    port_out = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_normal;
    t_ctc;
    t_fast;
    t_dual;
    t_extreme;
    report_and_stop;
  end
endmodule
